/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
   import upm_pkg::*;
   localparam int SPACING = 4;
   localparam int XMS = 3;
   logic sys_clk, rst_n, cfgWrite, rxCellStrobe, workingState, signalLoss, accessUpFault;
   logic accessDownFault, blockStrobe, blockReady, txOamReq, txCellValid, txErrValid, go;
   logic outOfDelineation, delineationLoss, combinedDelineationLoss, sectionAlarmRx, alarmOn;
   logic pathAlarmRx, sectionRemoteDefectRx, pathRemoteDefectRx, timingEnable;
   logic [1:0] cfgSelect, missedCell, maintFlowLoss;
   logic [2:0] fState;
   logic [3:0] txErrCount;
   logic [7:0] rxAlarmOctet, rxDefectOctet, ownParity, carriedParity, txAlarmOctet, txDefectOctet;
   logic [15:0] cfgData;
   upm_cell_e rxCellKind, goKind;
   upm_delin_e delinState;
   upm_level_e blockLevel, txOamLevel, txErrLevel;
   upm_net_e netState;
   int badCount, comparisons, missCnt, cnt, expMiss;
   logic [4:0] sb[$];
   // A millisecond is ten clocks here so the delineation timers finish quickly.
   upm_network_ctrl #(.MS_CYCLES(10)) upm_network_ctrl_inst (.*);
   upm_user_model upm_user_model_inst (.*);
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic cfg(input logic [1:0] sel, input logic [15:0] d);
      @(posedge sys_clk);
      cfgWrite <= 1'b1;
      cfgSelect <= sel;
      cfgData <= d;
      @(posedge sys_clk);
      cfgWrite <= 1'b0;
   endtask
   // The model registers go, so the controller takes the cell one edge later.
   task automatic send(input upm_cell_e k);
      @(posedge sys_clk);
      go <= 1'b1;
      goKind <= k;
      @(posedge sys_clk);
      go <= 1'b0;
      settle(2);
   endtask
   task automatic tx(input upm_level_e lv);
      @(posedge sys_clk);
      txOamReq <= 1'b1;
      txOamLevel <= lv;
      @(posedge sys_clk);
      txOamReq <= 1'b0;
      #1;
      chk(txCellValid, 1'b1);
   endtask
   // Holds the block until the queue accepts it or 50 clocks pass, then records the expected count.
   task automatic push(input upm_level_e lv);
      int n;
      n = 0;
      @(posedge sys_clk);
      blockStrobe <= 1'b1;
      blockLevel <= lv;
      ownParity <= 8'($urandom);
      carriedParity <= 8'($urandom);
      @(posedge sys_clk);
      while (blockReady !== 1'b1 && n < 50) begin
         n++;
         @(posedge sys_clk);
      end
      sb.push_back({lv, 4'($countones(ownParity ^ carriedParity))});
      blockStrobe <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Each error report must match the oldest block pushed; section-level misses are counted too.
   always @(posedge sys_clk) begin
      if (missedCell[0] === 1'b1) missCnt++;
      if (txErrValid === 1'b1) begin
         chk({11'h0, txErrLevel, txErrCount}, sb.size() > 0 ? {11'h0, sb.pop_front()} : '1);
      end
   end
   // The whole sequence needs well under a thousand clocks.
   initial begin
      repeat (20000) @(posedge sys_clk);
      badCount++;
      give_verdict();
   end
   initial begin
      void'($urandom(1));
      {rst_n, cfgWrite, signalLoss, accessUpFault, accessDownFault, blockStrobe} = '0;
      {txOamReq, go, alarmOn, cfgSelect, cfgData, ownParity, carriedParity} = '0;
      workingState = 1'b1;
      fState = 3'h1;
      goKind = CELL_USER;
      delinState = LOCKED_STATE;
      blockLevel = SECTION_LEVEL;
      txOamLevel = SECTION_LEVEL;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      settle(2);
      chk({maintFlowLoss, outOfDelineation, delineationLoss, txCellValid}, 5'h0);
      chk({netState, timingEnable}, {NET_OPER, 1'b1});
      cfg(2'h2, 16'(SPACING));
      cfg(2'h0, 16'h0);
      cfg(2'h1, 16'h0);
      // Spacing: covered cells only, the reference restarting its count on a miss.
      repeat (10) begin
         send(upm_cell_e'($urandom_range(1)));
         if (cnt >= SPACING) begin
            expMiss++;
            cnt = 0;
         end else begin
            cnt++;
         end
      end
      chk(16'(missCnt), 16'(expMiss));
      chk(maintFlowLoss, 2'h3);
      tx(SECTION_LEVEL);
      chk({txAlarmOctet, txDefectOctet[0]}, {8'hff, 1'b1});
      @(posedge sys_clk) fState <= 3'h3;
      send(CELL_SECTION_OAM);
      chk({maintFlowLoss[0], sectionRemoteDefectRx}, 2'h1);
      send(CELL_PATH_OAM);
      chk(maintFlowLoss, 2'h0);
      // Received alarm, then local signal loss.
      @(posedge sys_clk) alarmOn <= 1'b1;
      send(CELL_SECTION_OAM);
      chk(sectionAlarmRx, 1'b1);
      tx(PATH_LEVEL);
      chk({txAlarmOctet, txDefectOctet[0]}, {8'hff, 1'b1});
      tx(SECTION_LEVEL);
      chk(txDefectOctet[0], 1'b1);
      @(posedge sys_clk) alarmOn <= 1'b0;
      send(CELL_SECTION_OAM);
      tx(PATH_LEVEL);
      chk(txAlarmOctet, 8'h00);
      @(posedge sys_clk) signalLoss <= 1'b1;
      tx(SECTION_LEVEL);
      chk(txAlarmOctet, 8'hff);
      @(posedge sys_clk) signalLoss <= 1'b0;
      tx(SECTION_LEVEL);
      chk(txAlarmOctet, 8'h00);
      // Access-side faults.
      @(posedge sys_clk) accessUpFault <= 1'b1;
      tx(PATH_LEVEL);
      chk(txDefectOctet[0], 1'b1);
      tx(SECTION_LEVEL);
      chk(txDefectOctet[0], 1'b0);
      @(posedge sys_clk) accessUpFault <= 1'b0;
      @(posedge sys_clk) accessDownFault <= 1'b1;
      settle(3);
      chk(timingEnable, 1'b0);
      tx(PATH_LEVEL);
      chk(txAlarmOctet, 8'hff);
      @(posedge sys_clk) accessDownFault <= 1'b0;
      settle(3);
      chk(timingEnable, 1'b1);
      // Delineation with x of zero, then x of XMS milliseconds.
      @(posedge sys_clk) delinState <= SEARCH_STATE;
      settle(3);
      chk({outOfDelineation, delineationLoss, combinedDelineationLoss}, 3'h7);
      @(posedge sys_clk) delinState <= PROVISIONAL_LOCK_STATE;
      @(posedge sys_clk) delinState <= LOCKED_STATE;
      settle(3);
      chk({outOfDelineation, delineationLoss}, 2'h0);
      cfg(2'h0, 16'(XMS));
      @(posedge sys_clk) delinState <= SEARCH_STATE;
      settle(3);
      chk({outOfDelineation, delineationLoss}, 2'h2);
      settle(10 * (XMS + 2));
      chk({outOfDelineation, delineationLoss}, 2'h1);
      @(posedge sys_clk) delinState <= PROVISIONAL_LOCK_STATE;
      @(posedge sys_clk) delinState <= LOCKED_STATE;
      settle(10 * (XMS - 2));
      chk(delineationLoss, 1'b1);
      settle(10 * (XMS + 2));
      chk(delineationLoss, 1'b0);
      // Parity reports: fill the queue until it refuses, then drain it.
      repeat (8) push(upm_level_e'($urandom_range(1)));
      settle(2);
      chk(blockReady, 1'b0);
      repeat (8) tx(upm_level_e'($urandom_range(1)));
      tx(SECTION_LEVEL);
      chk({txErrValid, 15'(sb.size())}, 16'h0);
      give_verdict();
   end
endmodule

/* File: test/upm_checker.sv */
`timescale 1ns/1ns
// Port-level checks of the controller; figures are clock counts after the cause.
module upm_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic txOamReq,
   input wire upm_pkg::upm_level_e txOamLevel,
   input wire logic txCellValid,
   input wire logic [7:0] txAlarmOctet,
   input wire logic [7:0] txDefectOctet,
   input wire logic rxCellStrobe,
   input wire upm_pkg::upm_cell_e rxCellKind,
   input wire logic [7:0] rxAlarmOctet,
   input wire logic sectionAlarmRx,
   input wire logic signalLoss,
   input wire logic accessUpFault,
   input wire logic accessDownFault,
   input wire logic timingEnable,
   input wire upm_pkg::upm_delin_e delinState,
   input wire logic workingState,
   input wire logic outOfDelineation,
   input wire logic delineationLoss,
   input wire logic [1:0] missedCell,
   input wire logic [1:0] maintFlowLoss,
   input wire logic txErrValid
);
   import upm_pkg::*;
   logic txSec;
   logic txPath;
   // A cell taken on the request edge may change the received flags, so skip that case.
   assign txSec = txOamReq && txOamLevel == SECTION_LEVEL && !rxCellStrobe;
   assign txPath = txOamReq && txOamLevel == PATH_LEVEL && !rxCellStrobe;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////////////
   property p_tx_answer; txOamReq |=> txCellValid; endproperty
   property p_sec_alarm_tx; txSec && signalLoss |=> txAlarmOctet == 8'hff; endproperty
   property p_path_alarm_tx;
      txPath && (sectionAlarmRx || accessDownFault) |=> txAlarmOctet == 8'hff;
   endproperty
   property p_sec_alarm_rx;
      rxCellStrobe && rxCellKind == CELL_SECTION_OAM && rxAlarmOctet == 8'hff |=> sectionAlarmRx;
   endproperty
   property p_sec_defect_tx;
      txSec && (sectionAlarmRx || signalLoss) |=> txDefectOctet[0];
   endproperty
   property p_path_defect_tx; txPath && accessUpFault |=> txDefectOctet[0]; endproperty
   property p_ocd_set;
      workingState && $past(delinState) == LOCKED_STATE && delinState == SEARCH_STATE
         |-> ##[1:2] outOfDelineation;
   endproperty
   property p_flow_loss;
      $rose(maintFlowLoss[0]) |-> missedCell[0] || $past(missedCell[0]);
   endproperty
   property p_timing; $rose(accessDownFault) |-> ##[1:2] !timingEnable; endproperty
   a_tx_answer: assert property (p_tx_answer) else $error("no cell after request");
   a_sec_alarm_tx: assert property (p_sec_alarm_tx) else $error("section alarm missing");
   a_path_alarm_tx: assert property (p_path_alarm_tx) else $error("path alarm missing");
   a_sec_alarm_rx: assert property (p_sec_alarm_rx) else $error("alarm not seen");
   a_sec_defect_tx: assert property (p_sec_defect_tx) else $error("section flag missing");
   a_path_defect_tx: assert property (p_path_defect_tx) else $error("path flag missing");
   a_ocd_set: assert property (p_ocd_set) else $error("anomaly not raised");
   a_flow_loss: assert property (p_flow_loss) else $error("flow loss without miss");
   a_timing: assert property (p_timing) else $error("timing still given");
   // Main scenarios reached.
   c_report: cover property (txErrValid);
   c_flow: cover property (maintFlowLoss == 2'h3);
   c_delin: cover property (delineationLoss);
endmodule
bind upm_network_ctrl upm_checker upm_checker_inst (.*);

/* File: test/upm_user_model.sv */
`timescale 1ns/1ns
// Far-end equipment: one cell per go pulse, shaped by its layer-1 state.
module upm_user_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire upm_pkg::upm_cell_e goKind,
   input wire logic [2:0] fState,
   input wire logic alarmOn,
   output logic rxCellStrobe,
   output upm_pkg::upm_cell_e rxCellKind,
   output logic [7:0] rxAlarmOctet,
   output logic [7:0] rxDefectOctet
);
   import upm_pkg::*;
   logic [7:0] junk;
   logic operState;
   logic defectFlag;
   // Working states carry traffic only, so maintenance cells turn into user cells.
   assign operState = fState inside {3'h1, 3'h2, 3'h5};
   // Fault states facing a downstream defect raise the remote defect flag.
   assign defectFlag = fState == 3'h3 || (goKind[0] && fState inside {3'h4, 3'h6});
   ////////////////////////////////////////////////////////////////////////////////////////
   // Between cells the octets churn, so a stale value never passes for a fresh one.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rxCellStrobe <= 1'b0;
         junk <= 8'h5a;
      end else begin
         rxCellStrobe <= go;
         junk <= {junk[6:0], junk[7] ^ junk[5]};
      end
      rxCellKind <= (operState && goKind[1]) ? CELL_USER : goKind;
      rxAlarmOctet <= go ? (alarmOn ? 8'hff : 8'h00) : junk;
      rxDefectOctet <= go ? {7'h0, defectFlag} : ~junk;
   end
endmodule

/* File: verilog/upm_defs.svh */
// Summary of operation
// - Flag a missed maintenance cell when a level's OAM cell spacing is exceeded.
// - Declare maintenance flow loss after two consecutive missed cells of one level.
// - On signal, delineation or flow loss send section cell with octet 2 all ones.
// - On failure or received section alarm send path cell with octet 2 all ones.
// - Signal, delineation, flow loss or section alarm set bit 1 octet 30 in section cells.
// - Those defects or path alarm persisting seconds set bit 1 octet 30 in path cells; signal, delineation and flow loss set it at once here.
// - Locked to search transition in working state raises out of delineation.
// - Out of delineation ends on provisional to locked or on delineation loss.
// - Delineation loss follows out of delineation persisting x milliseconds.
// - Delineation loss clears after x continuous milliseconds in locked state.
// - With x zero both indications match and form one combined indication.
// - Path level covers user and idle cells; section level adds path OAM cells.
// - Count parity violations per block against carried value and report them back.
// - Upstream access fault makes network flag path but not section defect.
// - Downstream access fault stops network timing and sends path alarm.
// - Upstream interface fault makes network send section and path defects.
`ifndef UPM_DEFS_SVH
`define UPM_DEFS_SVH
`define UPM_ALARM_ON 8'hff
`define UPM_ALARM_OFF 8'h00
`define UPM_DEFECT_BIT 0
`define UPM_CLK_PERIOD_NS 10
`define UPM_MS_NS 1000000
`define UPM_MS_CYCLES (`UPM_MS_NS / `UPM_CLK_PERIOD_NS)
`define UPM_CFG_DELIN_MS 2'h0
`define UPM_CFG_RDI_MS 2'h1
`define UPM_CFG_SPACING 2'h2
`define UPM_RST_DELIN_MS 16'h0003
`define UPM_RST_RDI_MS 16'h09c4
`define UPM_RST_SPACING 16'h0200
`define UPM_FIFO_DEPTH 8
`define UPM_ERR_W 5
`endif

/* File: verilog/upm_fifo.sv */
`timescale 1ns/1ns
module upm_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr;
   logic [PW-1:0] rdPtr;
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   // Ready is registered from the next fill level, so it never promises a slot it lacks.
   assign next_count = count + CW'(push) - CW'(pop);
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];

   // Storage is written without reset; only pointers, count and inReady carry control state.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         inReady <= 1'b0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
         end
         if (pop) begin
            rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
         end
         count <= next_count;
         inReady <= (next_count < CW'(DEPTH));
      end
   end
endmodule

/* File: verilog/upm_network_ctrl.sv */
`timescale 1ns/1ns
`include "upm_defs.svh"
module upm_network_ctrl #(
   parameter int MS_CYCLES = `UPM_MS_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cfgWrite,
   input wire logic [1:0] cfgSelect,
   input wire logic [15:0] cfgData,
   input wire logic rxCellStrobe,
   input wire upm_pkg::upm_cell_e rxCellKind,
   input wire logic [7:0] rxAlarmOctet,
   input wire logic [7:0] rxDefectOctet,
   input wire upm_pkg::upm_delin_e delinState,
   input wire logic workingState,
   input wire logic signalLoss,
   input wire logic accessUpFault,
   input wire logic accessDownFault,
   input wire logic blockStrobe,
   input wire upm_pkg::upm_level_e blockLevel,
   input wire logic [7:0] ownParity,
   input wire logic [7:0] carriedParity,
   output logic blockReady,
   input wire logic txOamReq,
   input wire upm_pkg::upm_level_e txOamLevel,
   output logic txCellValid,
   output logic [7:0] txAlarmOctet,
   output logic [7:0] txDefectOctet,
   output logic txErrValid,
   output upm_pkg::upm_level_e txErrLevel,
   output logic [3:0] txErrCount,
   output logic [1:0] missedCell,
   output logic [1:0] maintFlowLoss,
   output logic outOfDelineation,
   output logic delineationLoss,
   output logic combinedDelineationLoss,
   output logic sectionAlarmRx,
   output logic pathAlarmRx,
   output logic sectionRemoteDefectRx,
   output logic pathRemoteDefectRx,
   output logic timingEnable,
   output upm_pkg::upm_net_e netState
);
   import upm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Tells whether a received cell counts toward the spacing of one monitoring level.
   function automatic logic coveredBy(input upm_level_e lv, input upm_cell_e kind);
      logic hit;
      hit = (kind == CELL_USER) || (kind == CELL_IDLE);
      if (lv == SECTION_LEVEL) begin
         hit = hit || (kind == CELL_PATH_OAM);
      end
      return hit;
   endfunction

   // Tells whether a received cell is the maintenance cell of one level.
   function automatic logic oamOf(input upm_level_e lv, input upm_cell_e kind);
      return (lv == SECTION_LEVEL) ? (kind == CELL_SECTION_OAM) : (kind == CELL_PATH_OAM);
   endfunction

   // Counts the parity bits that disagree; a byte gives at most eight.
   function automatic logic [3:0] violations(input logic [7:0] diff);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, diff[i]};
      end
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers and millisecond divider.

   logic [15:0] cfgDelinMs;
   logic [15:0] cfgRdiMs;
   logic [15:0] cfgSpacing;
   logic [16:0] msDiv;
   logic msTick;

   // Thresholds reset to defaults, and software may change them at run time.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfgDelinMs <= `UPM_RST_DELIN_MS;
         cfgRdiMs <= `UPM_RST_RDI_MS;
         cfgSpacing <= `UPM_RST_SPACING;
      end else if (cfgWrite) begin
         if (cfgSelect == `UPM_CFG_DELIN_MS) cfgDelinMs <= cfgData;
         if (cfgSelect == `UPM_CFG_RDI_MS) cfgRdiMs <= cfgData;
         if (cfgSelect == `UPM_CFG_SPACING) cfgSpacing <= cfgData;
      end
   end

   // One tick per millisecond feeds every persistence timer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         msDiv <= 17'h00000;
         msTick <= 1'b0;
      end else begin
         msTick <= (msDiv == 17'(MS_CYCLES - 1));
         msDiv <= (msDiv == 17'(MS_CYCLES - 1)) ? 17'h00000 : msDiv + 17'h00001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Received maintenance cells.

   wire secOamRx = rxCellStrobe && oamOf(SECTION_LEVEL, rxCellKind);
   wire pathOamRx = rxCellStrobe && oamOf(PATH_LEVEL, rxCellKind);
   wire alarmSeen = (rxAlarmOctet == `UPM_ALARM_ON);

   // Each indication holds until the next cell of its own level replaces it.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sectionAlarmRx <= 1'b0;
         sectionRemoteDefectRx <= 1'b0;
         pathAlarmRx <= 1'b0;
         pathRemoteDefectRx <= 1'b0;
      end else begin
         if (secOamRx) begin
            sectionAlarmRx <= alarmSeen;
            sectionRemoteDefectRx <= rxDefectOctet[`UPM_DEFECT_BIT];
         end
         if (pathOamRx) begin
            pathAlarmRx <= alarmSeen;
            pathRemoteDefectRx <= rxDefectOctet[`UPM_DEFECT_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Maintenance flow supervision, one lane per level.

   logic [15:0] spacingCnt [2];
   logic [1:0] missRun;
   logic [1:0] seenOam;
   logic [1:0] coveredCell;
   logic [1:0] spacingOver;

   // Spacing is counted in covered cells, so section OAM cells never pad the gap and path OAM cells pad only the section gap.
   assign seenOam = {pathOamRx, secOamRx};
   assign coveredCell[0] = rxCellStrobe && coveredBy(SECTION_LEVEL, rxCellKind);
   assign coveredCell[1] = rxCellStrobe && coveredBy(PATH_LEVEL, rxCellKind);
   assign spacingOver[0] = coveredCell[0] && (spacingCnt[0] >= cfgSpacing);
   assign spacingOver[1] = coveredCell[1] && (spacingCnt[1] >= cfgSpacing);

   // A miss restarts the spacing count; a second miss in a row declares flow loss.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 2; i++) spacingCnt[i] <= 16'h0000;
         missRun <= 2'b00;
         missedCell <= 2'b00;
         maintFlowLoss <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            missedCell[i] <= spacingOver[i];
            if (seenOam[i]) begin
               spacingCnt[i] <= 16'h0000;
               missRun[i] <= 1'b0;
               maintFlowLoss[i] <= 1'b0;
            end else if (spacingOver[i]) begin
               spacingCnt[i] <= 16'h0000;
               missRun[i] <= 1'b1;
               if (missRun[i]) maintFlowLoss[i] <= 1'b1;
            end else if (coveredCell[i]) begin
               spacingCnt[i] <= spacingCnt[i] + 16'h0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cell delineation supervision.

   upm_delin_e prevDelin;
   logic ocdExpired;
   logic lockExpired;
   logic next_ocd;
   logic next_lcd;
   wire zeroX = (cfgDelinMs == 16'h0000);
   wire lockToSearch = workingState && prevDelin == LOCKED_STATE && delinState == SEARCH_STATE;
   wire provToLock = prevDelin == PROVISIONAL_LOCK_STATE && delinState == LOCKED_STATE;
   wire lcdEnter = !zeroX && outOfDelineation && ocdExpired;

   // With x zero the loss follows the anomaly exactly, so both share one set and clear.
   always_comb begin
      next_ocd = outOfDelineation;
      next_lcd = delineationLoss;
      if (lockToSearch) begin
         next_ocd = 1'b1;
      end else if (provToLock || lcdEnter) begin
         next_ocd = 1'b0;
      end
      if (zeroX) begin
         next_lcd = next_ocd;
      end else if (lcdEnter) begin
         next_lcd = 1'b1;
      end else if (lockExpired) begin
         next_lcd = 1'b0;
      end
   end

   upm_persist_timer ocdTimer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .msTick(msTick),
      .active(outOfDelineation),
      .limit(cfgDelinMs),
      .expired(ocdExpired)
   );

   upm_persist_timer lockTimer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .msTick(msTick),
      .active(delineationLoss && delinState == LOCKED_STATE),
      .limit(cfgDelinMs),
      .expired(lockExpired)
   );

   // Delineation flags and the previous process state.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prevDelin <= SEARCH_STATE;
         outOfDelineation <= 1'b0;
         delineationLoss <= 1'b0;
         combinedDelineationLoss <= 1'b0;
      end else begin
         prevDelin <= delinState;
         outOfDelineation <= next_ocd;
         delineationLoss <= next_lcd;
         combinedDelineationLoss <= next_lcd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outgoing alarm and defect decisions.

   logic pathRdiExpired;
   wire flowLoss = |maintFlowLoss;
   wire localDefect = signalLoss || delineationLoss || flowLoss;
   wire sendSecAlarm = localDefect;
   wire sendPathAlarm = accessDownFault || sectionAlarmRx;
   wire sendSecRdi = localDefect || sectionAlarmRx;
   wire sendPathRdi = pathRdiExpired || accessUpFault || localDefect;

   // Path defect from received alarms waits for cfgRdiMs of persistence; local defects and upstream access fault set it at once.
   upm_persist_timer pathRdiTimer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .msTick(msTick),
      .active(localDefect || sectionAlarmRx || pathAlarmRx),
      .limit(cfgRdiMs),
      .expired(pathRdiExpired)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Block parity results queued for the far end.

   logic fifoOutValid;
   logic [`UPM_ERR_W-1:0] fifoOutData;
   wire popErr = txOamReq && fifoOutValid;

   // Back-pressure reaches the parity source through blockReady.
   upm_fifo #(
      .WIDTH(`UPM_ERR_W),
      .DEPTH(`UPM_FIFO_DEPTH)
   ) errFifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .inValid(blockStrobe),
      .inReady(blockReady),
      .inData({blockLevel, violations(ownParity ^ carriedParity)}),
      .outValid(fifoOutValid),
      .outReady(popErr),
      .outData(fifoOutData)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outgoing cell fields, one answer per request.

   wire [7:0] alarmField = ((txOamLevel == SECTION_LEVEL) ? sendSecAlarm : sendPathAlarm)
      ? `UPM_ALARM_ON : `UPM_ALARM_OFF;
   wire defectField = (txOamLevel == SECTION_LEVEL) ? sendSecRdi : sendPathRdi;

   // Fields are sampled at the request so a cell never mixes two decisions.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         txCellValid <= 1'b0;
         txAlarmOctet <= `UPM_ALARM_OFF;
         txDefectOctet <= 8'h00;
         txErrValid <= 1'b0;
         txErrLevel <= SECTION_LEVEL;
         txErrCount <= 4'h0;
      end else begin
         txCellValid <= txOamReq;
         txErrValid <= popErr;
         if (txOamReq) begin
            txAlarmOctet <= alarmField;
            txDefectOctet <= {7'h00, defectField};
            txErrLevel <= upm_level_e'(fifoOutData[`UPM_ERR_W-1]);
            txErrCount <= fifoOutData[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Network fault state and timing.

   logic [3:0] faults;
   upm_net_e next_net;

   // Several faults at once collapse into one combined state.
   assign faults = {localDefect, accessDownFault,
      sectionRemoteDefectRx && pathRemoteDefectRx, accessUpFault};

   always_comb begin
      case (faults)
         4'b0000: next_net = NET_OPER;
         4'b0001: next_net = NET_UPSTREAM_ACCESS;
         4'b0010: next_net = NET_DOWNSTREAM_IFACE;
         4'b0100: next_net = NET_DOWNSTREAM_ACCESS;
         4'b1000: next_net = NET_UPSTREAM_IFACE;
         default: next_net = NET_MULTI;
      endcase
   end

   // Timing is withheld while the access side downstream has failed.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         netState <= NET_OPER;
         timingEnable <= 1'b0;
      end else begin
         netState <= next_net;
         timingEnable <= !accessDownFault;
      end
   end
endmodule

/* File: verilog/upm_persist_timer.sv */
`timescale 1ns/1ns
module upm_persist_timer (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic msTick,
   input wire logic active,
   input wire logic [15:0] limit,
   output logic expired
);
   logic [15:0] count;
   logic [15:0] next_count;

   // The count saturates so that a condition held for very long stays expired.
   assign next_count = !active ? 16'h0000 :
      (msTick && count != 16'hffff) ? count + 16'h0001 : count;

   // Whole milliseconds are counted, so the first partial one adds up to one tick of slack.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count <= 16'h0000;
         expired <= 1'b0;
      end else begin
         count <= next_count;
         expired <= active && (next_count >= limit);
      end
   end
endmodule

/* File: verilog/upm_pkg.sv */
package upm_pkg;
   typedef enum logic [1:0] {SEARCH_STATE, PROVISIONAL_LOCK_STATE, LOCKED_STATE} upm_delin_e;
   typedef enum logic {SECTION_LEVEL, PATH_LEVEL} upm_level_e;
   typedef enum logic [1:0] {CELL_USER, CELL_IDLE, CELL_SECTION_OAM, CELL_PATH_OAM} upm_cell_e;
   typedef enum logic [2:0] {
      NET_OPER, NET_UPSTREAM_ACCESS, NET_DOWNSTREAM_IFACE, NET_DOWNSTREAM_ACCESS,
      NET_UPSTREAM_IFACE, NET_MULTI
   } upm_net_e;
endpackage
